// [clock_event_pkg.sv]
// constants, carrier types and rule summary for the clock event status read-out
// How it works
// - a status read clears each reported event flag the cycle after its data line is first driven.
// - the per-channel sync flag clears when the status read strobe drops.
// - each read reports a channel event once, and only if it really happened.
// - overflow and external events are reported on separate data bits.
// - enabled overflow drives accumulator data bit 0 during a status read.
// - both bus control outputs are asserted while status is presented.
// - timing pulse three of a status read clears the overflow flag if overflow is enabled.
// - three identical input channels, each with own pulse and level output.
// - a comparator rising edge gives one event pulse to the status logic.
// - the fired level output follows the comparator until it resets.
// - an event pulse sets its flag only if that channel is enabled.
// - read strobe leading edge copies flag into sync, sync drives the line.
package clock_event_pkg;

  localparam int NUM_CH = 3;
  localparam int AXI_AW = 4;
  localparam int ACC_W  = 12;

  localparam logic [AXI_AW-1:0] ENABLE_OFFSET = 4'h0;
  localparam logic [AXI_AW-1:0] STATUS_OFFSET = 4'h4;

  // accumulator bit positions
  localparam int OVF_BIT     = 0;
  localparam int CH1_BIT     = 11;
  localparam int CH_BIT_LOW  = 9;

  // status register field positions
  localparam int ST_OVF_POS   = 0;
  localparam int ST_FLAG_POS  = 1;
  localparam int ST_SYNC_POS  = 4;
  localparam int ST_FIRED_POS = 7;
  localparam int ST_OVFS_POS  = 10;
  localparam int ST_OVFEN_POS = 11;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [AXI_AW-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [AXI_AW-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axil_rsp_t;

endpackage

// [clock_event_status.sv]
// status read-out of the real-time clock: event and overflow flags, cpu jam port, axi4-lite
`timescale 1ns/1ns
`default_nettype none

module clock_event_status
(
  input  wire logic                               clk_sys,
  input  wire logic                               rst_n,
  input  wire clock_event_pkg::axil_req_t         axil_req,
  output var  clock_event_pkg::axil_rsp_t         axil_rsp,
  input  wire logic                               clock_status_read,
  input  wire logic                               enable_load_instr,
  input  wire logic                               timing_pulse_three,
  input  wire logic                               system_init,
  input  wire logic [clock_event_pkg::ACC_W-1:0]  accum_in,
  input  wire logic                               counter_overflow,
  input  wire logic [clock_event_pkg::NUM_CH-1:0] comparator_fired,
  output logic      [clock_event_pkg::ACC_W-1:0]  accum_data_out,
  output logic                                    bus_ctl_0,
  output logic                                    bus_ctl_1,
  output logic      [clock_event_pkg::NUM_CH-1:0] input_event_pulse,
  output logic      [clock_event_pkg::NUM_CH-1:0] input_fired_level
);
  import clock_event_pkg::*;

  typedef struct packed {
    logic [NUM_CH-1:0] fire_s1;
    logic [NUM_CH-1:0] fire_s2;
    logic [NUM_CH-1:0] fire_s3;
    logic [NUM_CH-1:0] pulse;
    logic [NUM_CH-1:0] ch_en;
    logic [NUM_CH-1:0] evt_flag;
    logic [NUM_CH-1:0] evt_sync;
    logic              ovf_en;
    logic              ovf_flag;
    logic              ovf_sync;
    logic              strobe_q;
    logic              lead_q;
    logic [ACC_W-1:0]  data_out;
    logic              aw_got;
    logic [AXI_AW-1:0] awaddr;
    logic              w_got;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } state_t;

  localparam state_t STATE_RESET = '{
    fire_s1: '0, fire_s2: '0, fire_s3: '0, pulse: '0, ch_en: '0,
    evt_flag: '0, evt_sync: '0, ovf_en: 1'b0, ovf_flag: 1'b0, ovf_sync: 1'b0,
    strobe_q: 1'b0, lead_q: 1'b0, data_out: '0, aw_got: 1'b0, awaddr: '0,
    w_got: 1'b0, wdata: '0, wstrb: '0, bvalid: 1'b0, bresp: RESP_OKAY,
    rvalid: 1'b0, rdata: RDATA_RESET, rresp: RESP_OKAY};

  // channel 1 sits on the highest of the three accumulator channel bits
  function automatic logic [NUM_CH-1:0] word_to_ch(input logic [ACC_W-1:0] w);
    logic [NUM_CH-1:0] c;
    c = '0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      c[i] = w[CH1_BIT-i];
    end
    return c;
  endfunction

  function automatic logic [ACC_W-1:0] ch_to_word(input logic [NUM_CH-1:0] c);
    logic [ACC_W-1:0] w;
    w = '0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      w[CH1_BIT-i] = c[i];
    end
    return w;
  endfunction

  logic   rst_s1_r;
  logic   rst_sync_n_r;
  state_t state_r;
  state_t state_nxt;

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_r     <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end
    else
    begin
      rst_s1_r     <= 1'b1;
      rst_sync_n_r <= rst_s1_r;
    end
  end

  logic              strobe_lead;
  logic              strobe_trail;
  logic [NUM_CH-1:0] evt_set;
  logic [NUM_CH-1:0] evt_clr;
  logic              ovf_clr;
  logic              do_write;
  logic [AXI_AW-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic [31:0]       status_word;

  always_comb
  begin
    state_nxt    = state_r;
    strobe_lead  = clock_status_read && !state_r.strobe_q;
    strobe_trail = !clock_status_read && state_r.strobe_q;

    // comparator path: two-flop sync, then one more stage for the edge
    state_nxt.fire_s1 = comparator_fired;
    state_nxt.fire_s2 = state_r.fire_s1;
    state_nxt.fire_s3 = state_r.fire_s2;
    state_nxt.pulse   = state_r.fire_s2 & ~state_r.fire_s3;

    // a pulse only counts on an enabled channel
    evt_set = state_r.pulse & state_r.ch_en;
    // the cycle after the leading edge, reported channels are cleared
    evt_clr = state_r.lead_q ? state_r.evt_sync : '0;
    // set wins over clear, so an event during the clear is kept for next read
    state_nxt.evt_flag = (state_r.evt_flag & ~evt_clr) | evt_set;

    if (strobe_lead)
    begin
      state_nxt.evt_sync = state_r.evt_flag;
      state_nxt.ovf_sync = state_r.ovf_flag && state_r.ovf_en;
    end
    else if (strobe_trail)
    begin
      state_nxt.evt_sync = '0;
      state_nxt.ovf_sync = 1'b0;
    end
    state_nxt.strobe_q = clock_status_read;
    state_nxt.lead_q   = strobe_lead;

    ovf_clr = clock_status_read && timing_pulse_three && state_r.ovf_en;
    state_nxt.ovf_flag = (state_r.ovf_flag && !ovf_clr) || counter_overflow;

    if (system_init)
    begin
      state_nxt.evt_flag = '0;
      state_nxt.evt_sync = '0;
      state_nxt.ovf_flag = 1'b0;
      state_nxt.ovf_sync = 1'b0;
    end

    // jam data: overflow on bit 0, channels on their own bits
    state_nxt.data_out = '0;
    if (clock_status_read)
    begin
      state_nxt.data_out = ch_to_word(state_nxt.evt_sync);
      state_nxt.data_out[OVF_BIT] = state_nxt.ovf_sync;
    end

    // axi write: address and data taken in either order
    if (axil_req.awvalid && axil_rsp.awready)
    begin
      state_nxt.aw_got = 1'b1;
      state_nxt.awaddr = axil_req.awaddr;
    end
    if (axil_req.wvalid && axil_rsp.wready)
    begin
      state_nxt.w_got = 1'b1;
      state_nxt.wdata = axil_req.wdata;
      state_nxt.wstrb = axil_req.wstrb;
    end
    do_write = state_nxt.aw_got && state_nxt.w_got && !state_r.bvalid;
    wr_addr  = state_nxt.awaddr;
    wr_data  = state_nxt.wdata;
    wr_strb  = state_nxt.wstrb;
    if (do_write)
    begin
      state_nxt.aw_got = 1'b0;
      state_nxt.w_got  = 1'b0;
      state_nxt.bvalid = 1'b1;
      if (wr_addr[AXI_AW-1:2] == ENABLE_OFFSET[AXI_AW-1:2])
      begin
        state_nxt.bresp = RESP_OKAY;
        if (wr_strb[0])
        begin
          state_nxt.ovf_en = wr_data[OVF_BIT];
        end
        if (wr_strb[1])
        begin
          state_nxt.ch_en = word_to_ch(wr_data[ACC_W-1:0]);
        end
      end
      else if (wr_addr[AXI_AW-1:2] == STATUS_OFFSET[AXI_AW-1:2])
      begin
        state_nxt.bresp = RESP_SLVERR;
      end
      else
      begin
        state_nxt.bresp = RESP_DECERR;
      end
    end
    else if (state_r.bvalid && axil_req.bready)
    begin
      state_nxt.bvalid = 1'b0;
    end

    // enable load from the cpu wins over a bus write in the same cycle
    if (enable_load_instr)
    begin
      state_nxt.ovf_en = accum_in[OVF_BIT];
      state_nxt.ch_en  = word_to_ch(accum_in);
    end

    status_word = '0;
    status_word[ST_OVF_POS]                  = state_r.ovf_flag;
    status_word[ST_FLAG_POS +: NUM_CH]       = state_r.evt_flag;
    status_word[ST_SYNC_POS +: NUM_CH]       = state_r.evt_sync;
    status_word[ST_FIRED_POS +: NUM_CH]      = state_r.fire_s2;
    status_word[ST_OVFS_POS]                 = state_r.ovf_sync;
    status_word[ST_OVFEN_POS]                = state_r.ovf_en;

    if (axil_req.arvalid && axil_rsp.arready)
    begin
      state_nxt.rvalid = 1'b1;
      state_nxt.rresp  = RESP_OKAY;
      if (axil_req.araddr[AXI_AW-1:2] == ENABLE_OFFSET[AXI_AW-1:2])
      begin
        state_nxt.rdata = 32'(ch_to_word(state_r.ch_en));
        state_nxt.rdata[OVF_BIT] = state_r.ovf_en;
      end
      else if (axil_req.araddr[AXI_AW-1:2] == STATUS_OFFSET[AXI_AW-1:2])
      begin
        state_nxt.rdata = status_word;
      end
      else
      begin
        state_nxt.rdata = '0;
        state_nxt.rresp = RESP_DECERR;
      end
    end
    else if (state_r.rvalid && axil_req.rready)
    begin
      state_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n_r)
  begin
    if (!rst_sync_n_r)
    begin
      state_r <= STATE_RESET;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  always_comb
  begin
    axil_rsp.awready = !state_r.aw_got && !state_r.bvalid;
    axil_rsp.wready  = !state_r.w_got && !state_r.bvalid;
    axil_rsp.bresp   = state_r.bresp;
    axil_rsp.bvalid  = state_r.bvalid;
    axil_rsp.arready = !state_r.rvalid;
    axil_rsp.rdata   = state_r.rdata;
    axil_rsp.rresp   = state_r.rresp;
    axil_rsp.rvalid  = state_r.rvalid;
  end

  assign accum_data_out    = state_r.data_out;
  assign bus_ctl_0         = state_r.strobe_q;
  assign bus_ctl_1         = state_r.strobe_q;
  assign input_event_pulse = state_r.pulse;
  assign input_fired_level = state_r.fire_s2;

endmodule // clock_event_status

`default_nettype wire

// [clock_event_status_chk.sv]
// port assertions for the clock event status read-out
`timescale 1ns/1ns
`default_nettype none
module clock_event_status_chk
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        clock_status_read,
  input wire logic [2:0]  comparator_fired,
  input wire logic [11:0] accum_data_out,
  input wire logic        bus_ctl_0,
  input wire logic        bus_ctl_1,
  input wire logic [2:0]  input_event_pulse,
  input wire logic [2:0]  input_fired_level
);
  logic [2:0] lvl_r;
  logic [2:0] rise_r;
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      {lvl_r, rise_r} <= 6'h00;
    else
      {lvl_r, rise_r} <= {input_fired_level, input_fired_level & ~lvl_r};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ctl_start_a: assert property ($rose(clock_status_read) |=> bus_ctl_0 && bus_ctl_1)
    else $error("bus control not raised by strobe");
  ctl_pair_a: assert property (bus_ctl_0 == bus_ctl_1)
    else $error("bus control lines differ");
  read_end_a: assert property ($fell(clock_status_read) |=> !bus_ctl_0 && accum_data_out == 12'h000)
    else $error("read not closed after strobe drop");
  data_idle_a: assert property (!bus_ctl_0 |-> accum_data_out == 12'h000)
    else $error("jam data outside a read");
  data_hold_a: assert property (bus_ctl_0 && $past(bus_ctl_0) |-> $stable(accum_data_out))
    else $error("jam data changed within a read");
  bit_split_a: assert property (accum_data_out[8:1] == 8'h00)
    else $error("status on unused data bits");
  level_sync_a: assert property (input_fired_level == $past(comparator_fired, 2))
    else $error("fired level does not follow comparator");
  pulse_rise_a: assert property (input_event_pulse == rise_r)
    else $error("event pulse not single on rise");
endmodule // clock_event_status_chk
bind clock_event_status clock_event_status_chk chk_i (.clk_sys(clk_sys), .rst_n(rst_n),
  .clock_status_read(clock_status_read), .comparator_fired(comparator_fired),
  .accum_data_out(accum_data_out), .bus_ctl_0(bus_ctl_0), .bus_ctl_1(bus_ctl_1),
  .input_event_pulse(input_event_pulse), .input_fired_level(input_fired_level));
`default_nettype wire

// [cpu_bus_model.sv]
// cpu side of the status jam port: read strobe, timing pulse, enable load
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_model
(
  input  wire logic        clk_sys,
  input  wire logic [11:0] accum_data_out,
  input  wire logic        bus_ctl_0,
  input  wire logic        bus_ctl_1,
  output var  logic        clock_status_read,
  output var  logic        timing_pulse_three,
  output var  logic        enable_load_instr,
  output var  logic [11:0] accum_in
);
  initial {clock_status_read, timing_pulse_three, enable_load_instr, accum_in} = 15'h0000;
  task automatic load(input logic [11:0] v);
    begin
      accum_in <= v;
      enable_load_instr <= 1'b1;
      @(posedge clk_sys);
      enable_load_instr <= 1'b0;
      accum_in <= ~v;
    end
  endtask
  task automatic stat_read(output logic [11:0] d);
    int k;
    begin
      d = 12'h000;
      clock_status_read <= 1'b1;
      for (k = 0; k < 5; k++) // strobe of 500 ns
      begin
        @(negedge clk_sys);
        if (bus_ctl_0 && bus_ctl_1) // jam only with both controls
          d = accum_data_out;
        @(posedge clk_sys);
        timing_pulse_three <= (k == 2);
      end
      clock_status_read <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
  endtask
endmodule // cpu_bus_model
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the clock event status read-out
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import clock_event_pkg::*;
  logic        clk_sys, rst_n, system_init, counter_overflow, aw, wd, ar, done;
  logic        clock_status_read, enable_load_instr, timing_pulse_three, bus_ctl_0, bus_ctl_1;
  logic [2:0]  comparator_fired, input_event_pulse, input_fired_level;
  logic [11:0] accum_in, accum_data_out, d, en;
  logic [31:0] v, rd;
  logic [1:0]  rs;
  axil_req_t   req;
  axil_rsp_t   rsp;
  int          failures, checks_done, cyc, i, j, flags, ovf;
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  clock_event_status clock_event_status_i (.clk_sys(clk_sys), .rst_n(rst_n), .axil_req(req),
    .axil_rsp(rsp), .clock_status_read(clock_status_read), .enable_load_instr(enable_load_instr),
    .timing_pulse_three(timing_pulse_three), .system_init(system_init), .accum_in(accum_in),
    .counter_overflow(counter_overflow), .comparator_fired(comparator_fired),
    .accum_data_out(accum_data_out), .bus_ctl_0(bus_ctl_0), .bus_ctl_1(bus_ctl_1),
    .input_event_pulse(input_event_pulse), .input_fired_level(input_fired_level));
  cpu_bus_model cpu_bus_model_i (.clk_sys(clk_sys), .accum_data_out(accum_data_out),
    .bus_ctl_0(bus_ctl_0), .bus_ctl_1(bus_ctl_1), .clock_status_read(clock_status_read),
    .timing_pulse_three(timing_pulse_three), .enable_load_instr(enable_load_instr),
    .accum_in(accum_in));
  task automatic end_sim;
    begin
      if (failures == 0 && checks_done > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    begin
      checks_done++;
      if (g !== e)
      begin
        failures++;
        $display("wrong value at %0t: expected %h got %h", $time, e, g);
      end
    end
  endtask
  // one axi4-lite transfer; response and read data land in rs and rd
  task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] w);
    begin
      done = 1'b0;
      req.awaddr <= a;
      req.araddr <= a;
      req.wdata <= w;
      req.awvalid <= wr;
      req.wvalid <= wr;
      req.bready <= wr;
      req.arvalid <= !wr;
      req.rready <= !wr;
      while (!done)
      begin
        @(negedge clk_sys);
        {aw, wd, ar} = {rsp.awready, rsp.wready, rsp.arready};
        done = wr ? rsp.bvalid : rsp.rvalid;
        rs = wr ? rsp.bresp : rsp.rresp;
        rd = rsp.rdata;
        @(posedge clk_sys);
        if (aw) req.awvalid <= 1'b0;
        if (wd) req.wvalid <= 1'b0;
        if (ar) req.arvalid <= 1'b0;
      end
      req.bready <= 1'b0;
      req.rready <= 1'b0;
      // one edge between calls, so no request signal is assigned twice in one step
      @(posedge clk_sys);
    end
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      end_sim();
    end
  end
  initial
  begin
    {failures, checks_done, cyc, flags, ovf} = '0;
    {rst_n, system_init, counter_overflow, comparator_fired} = 6'h00;
    req = '0;
    req.wstrb = 4'hf;
    v = $urandom(38);
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    axi(1'b1, ENABLE_OFFSET, v);
    chk(RESP_OKAY, rs);
    axi(1'b0, ENABLE_OFFSET, 32'h0);
    chk(v & 32'h0000_0e01, rd);
    axi(1'b0, STATUS_OFFSET, 32'h0);
    chk({20'h0, v[0], 11'h0}, rd);
    axi(1'b1, STATUS_OFFSET, v);
    chk(RESP_SLVERR, rs);
    axi(1'b0, 4'h8, 32'h0);
    chk(RESP_DECERR, rs);
    chk(32'h0000_0000, rd);
    // byte 0 strobe only: overflow enable changes, channel enables keep their value
    req.wstrb <= 4'h1;
    axi(1'b1, ENABLE_OFFSET, ~v);
    chk(RESP_OKAY, rs);
    axi(1'b0, ENABLE_OFFSET, 32'h0);
    chk((v & 32'h0000_0e00) | {31'h0000_0000, ~v[0]}, rd);
    for (i = 0; i < 8; i++)
    begin
      en = $urandom;
      cpu_bus_model_i.load(en);
      v = $urandom;
      comparator_fired <= v[2:0];
      counter_overflow <= v[3];
      @(posedge clk_sys);
      counter_overflow <= 1'b0;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(v[2:0], input_fired_level);
      chk(v[2:0], input_event_pulse);
      @(posedge clk_sys);
      comparator_fired <= 3'h0;
      flags = flags | (v[2:0] & {en[9], en[10], en[11]});
      ovf = ovf | v[3];
      if (i == 3)
      begin
        system_init <= 1'b1;
        @(posedge clk_sys);
        system_init <= 1'b0;
        {flags, ovf} = '0;
      end
      for (j = 0; j < 2; j++)
      begin
        cpu_bus_model_i.stat_read(d);
        chk({flags[0], flags[1], flags[2], 8'h00, ovf[0] & en[0]}, d);
        flags = 0;
        if (en[0]) ovf = 0;
      end
    end
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
